// ===== core/amc_ctrl.sv
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
module amc_ctrl #(
  parameter int RATIO_A = amc_pkg::RATIO_A,
  parameter int RATIO_B = amc_pkg::RATIO_B,
  parameter int MOD_DIV = amc_pkg::MOD_DIV,
  parameter int SPI_READY_CYC = amc_pkg::SPI_READY_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic digital_io_supply_ok,
  input wire logic digital_regulator_ok,
  input wire logic [amc_pkg::NUM_ANALOG_MON-1:0] analog_supply_ok,
  input wire logic start,
  output logic conversion_ready_n,
  output logic common_mode_output_enable,
  output logic high_speed_mode,
  output logic filter_active,
  output logic sampling_active
);
  // Conversion periods in master clocks; modulator runs at clock / MOD_DIV
  localparam int PER_A = MOD_DIV * RATIO_A;
  localparam int PER_B = MOD_DIV * RATIO_B;
  localparam int PER_B3 = PER_B * amc_pkg::AVG_LOW;
  localparam int PER_B5 = PER_B * amc_pkg::AVG_HIGH;
  localparam int CW = $clog2(PER_B5 + 1);

  // Each limit has its own message so a bad override is easy to trace
  if (RATIO_A < 2 || RATIO_B < 2) begin : g_bad_ratio
    $error("amc_ctrl: decimation ratios below 2 are not supported");
  end

  if (MOD_DIV < 1) begin : g_bad_div
    $error("amc_ctrl: modulator divider must be at least 1");
  end

  if (CW > 31) begin : g_bad_width
    $error("amc_ctrl: conversion period too long for the counter");
  end

  if (SPI_READY_CYC < 1 || SPI_READY_CYC > PER_B5) begin : g_bad_spi
    $error("amc_ctrl: interface ready delay out of range");
  end

  // Wake count shares the period counter, so it must fit in it
  if (amc_pkg::STANDBY_EXIT_CYC > PER_B5) begin : g_bad_wake
    $error("amc_ctrl: standby exit longer than any period");
  end

  typedef enum logic [2:0] {
    S_POR_WAIT,
    S_SPI_WAIT,
    S_STOPPED,
    S_WAKE,
    S_CONVERT
  } amc_state_t;

  amc_state_t state_r, state_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [CW-1:0] period;
  logic [1:0] low_cnt_r;
  logic cm_en_r;
  amc_pkg::amc_cfg_t cfg_r;
  logic por_flag_r, analog_undervoltage_flag_r;
  logic conv_start, conv_done;
  logic supplies_ok, analog_low;
  logic [amc_pkg::NUM_ANALOG_MON-1:0] mon_low;
  logic wr_acc, setup;
  logic status_wr;
  logic hit_first;
  logic hit_second;
  logic hit_status;
  logic [31:0] rd_word;
  logic rd_err;
  amc_pkg::amc_stat_t stat;

  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pready && pwrite;
  assign hit_first = (paddr == amc_pkg::ADDR_FIRST_CFG);
  assign hit_second = (paddr == amc_pkg::ADDR_SECOND_CFG);
  assign hit_status = (paddr == amc_pkg::ADDR_STATUS);
  assign status_wr = wr_acc && hit_status;
  assign supplies_ok = digital_io_supply_ok && digital_regulator_ok;

  // One low report per monitor; any single one is enough
  for (genvar m = 0; m < amc_pkg::NUM_ANALOG_MON; m++) begin : g_mon
    assign mon_low[m] = !analog_supply_ok[m];
  end
  // A digital I/O supply dip also sets the analog undervoltage flag
  assign analog_low = (|mon_low) || !digital_io_supply_ok;

  always_comb begin
    period = CW'(PER_A);
    if (cfg_r.cascade) begin
      period = cfg_r.avg_five ? CW'(PER_B5) : CW'(PER_B3);
    end else if (cfg_r.ratio_b) begin
      period = CW'(PER_B);
    end
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    conv_start = 1'b0;
    conv_done = 1'b0;
    case (state_r)
      S_POR_WAIT: begin
        cnt_nxt = '0;
        if (supplies_ok) begin
          state_nxt = S_SPI_WAIT;
        end
      end
      S_SPI_WAIT: begin
        cnt_nxt = cnt_r + CW'(1);
        if (cnt_r == CW'(SPI_READY_CYC - 1)) begin
          cnt_nxt = '0;
          if (start) begin
            state_nxt = S_CONVERT;
            conv_start = 1'b1;
          end else begin
            state_nxt = S_STOPPED;
          end
        end
      end
      S_STOPPED: begin
        cnt_nxt = '0;
        if (start) begin
          if (cfg_r.standby_select) begin
            state_nxt = S_WAKE;
          end else begin
            state_nxt = S_CONVERT;
            conv_start = 1'b1;
          end
        end
      end
      S_WAKE: begin
        cnt_nxt = cnt_r + CW'(1);
        if (cnt_r == CW'(amc_pkg::STANDBY_EXIT_CYC - 1)) begin
          state_nxt = S_CONVERT;
          cnt_nxt = '0;
          conv_start = 1'b1;
        end
      end
      S_CONVERT: begin
        cnt_nxt = cnt_r + CW'(1);
        if (cnt_r >= period - CW'(1)) begin
          conv_done = 1'b1;
          cnt_nxt = '0;
          // Ongoing conversion always finishes before a stop
          if (!start) begin
            state_nxt = S_STOPPED;
          end
        end
      end
      default: begin
        state_nxt = S_POR_WAIT;
        cnt_nxt = '0;
      end
    endcase
    // Losing a digital supply drops back to reset hold
    if (!supplies_ok) begin
      state_nxt = S_POR_WAIT;
      cnt_nxt = '0;
    end
  end

  // presetn (digital supply power-on) clears control state at once; a supply loss clears it at the next clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_POR_WAIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_ready_n <= 1'b0;
      low_cnt_r <= 2'h0;
    end else if (state_r == S_SPI_WAIT && state_nxt != S_SPI_WAIT) begin
      conversion_ready_n <= 1'b1;
      low_cnt_r <= 2'h0;
    end else if (conv_start) begin
      conversion_ready_n <= 1'b1;
      low_cnt_r <= 2'h0;
    end else if (conv_done) begin
      conversion_ready_n <= 1'b0;
      low_cnt_r <= amc_pkg::READY_LOW_CYC;
    end else if (low_cnt_r != 2'h0) begin
      low_cnt_r <= low_cnt_r - 2'h1;
      if (low_cnt_r == 2'h1) begin
        conversion_ready_n <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_active <= 1'b0;
    end else begin
      filter_active <= (state_nxt == S_CONVERT);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sampling_active <= 1'b0;
    end else begin
      case (state_nxt)
        S_CONVERT, S_WAKE: sampling_active <= 1'b1;
        // Idle keeps sampling; standby halts it
        S_STOPPED: sampling_active <= !cfg_r.standby_select;
        default: sampling_active <= 1'b0;
      endcase
    end
  end

  // Configuration registers; analog supplies never touch them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cm_en_r <= amc_pkg::FC_CM_EN_RST;
    end else if (wr_acc && hit_first) begin
      cm_en_r <= pwdata[amc_pkg::FC_CM_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= amc_pkg::SC_RST;
    end else if (wr_acc && hit_second) begin
      cfg_r <= amc_pkg::amc_cfg_t'(pwdata[amc_pkg::SC_WIDTH-1:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      common_mode_output_enable <= amc_pkg::FC_CM_EN_RST;
    end else begin
      common_mode_output_enable <= cm_en_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_speed_mode <= amc_pkg::SC_RST.high_speed;
    end else begin
      high_speed_mode <= cfg_r.high_speed;
    end
  end

  // Sticky flags: presetn sets the POR flag; the analog set term is last so it wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_flag_r <= 1'b1;
    end else if (status_wr && pwdata[amc_pkg::ST_POR_BIT]) begin
      por_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_undervoltage_flag_r <= 1'b1;
    end else begin
      if (status_wr && pwdata[amc_pkg::ST_ALV_BIT]) begin
        analog_undervoltage_flag_r <= 1'b0;
      end
      if (analog_low) begin
        analog_undervoltage_flag_r <= 1'b1;
      end
    end
  end

  always_comb begin
    stat.por_flag = por_flag_r;
    stat.analog_undervoltage_flag = analog_undervoltage_flag_r;
    stat.converting = (state_r == S_CONVERT) || (state_r == S_WAKE);
    stat.released = (state_r != S_POR_WAIT) && (state_r != S_SPI_WAIT);
  end

  // Unused bits read zero; an unmapped address reads zero with an error
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_err = 1'b0;
    if (hit_first) begin
      rd_word[amc_pkg::FC_CM_EN_BIT] = cm_en_r;
    end else if (hit_second) begin
      rd_word[amc_pkg::SC_WIDTH-1:0] = cfg_r;
    end else if (hit_status) begin
      rd_word[amc_pkg::ST_WIDTH-1:0] = stat;
    end else begin
      rd_err = 1'b1;
    end
  end

  // One wait-free access phase; data captured at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && rd_err;
      if (setup) begin
        prdata <= rd_word;
      end
    end
  end
endmodule

// ===== core/amc_pkg.sv
package amc_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_FIRST_CFG = 8'h00;
  localparam logic [7:0] ADDR_SECOND_CFG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // first_config_reg fields
  localparam int FC_CM_EN_BIT = 0;
  localparam logic FC_CM_EN_RST = 1'b0;

  // second_config_reg layout, low bits of the word
  localparam int SC_WIDTH = 5;
  typedef struct packed {
    logic avg_five;
    logic ratio_b;
    logic cascade;
    logic standby_select;
    logic high_speed;
  } amc_cfg_t;
  localparam amc_cfg_t SC_RST = '{
    avg_five: 1'b0,
    ratio_b: 1'b0,
    cascade: 1'b0,
    standby_select: 1'b0,
    high_speed: 1'b1
  };

  // Status layout, low bits of the word
  localparam int ST_WIDTH = 4;
  typedef struct packed {
    logic released;
    logic converting;
    logic analog_undervoltage_flag;
    logic por_flag;
  } amc_stat_t;
  localparam int ST_POR_BIT = 0;
  localparam int ST_ALV_BIT = 1;

  // Filter ratios and timing
  localparam int RATIO_A = 26667;
  localparam int RATIO_B = 32000;
  localparam int MOD_DIV = 2;
  localparam int AVG_LOW = 3;
  localparam int AVG_HIGH = 5;
  localparam int STANDBY_EXIT_CYC = 24;
  localparam logic [1:0] READY_LOW_CYC = 2'h3;
  localparam int SPI_READY_CYC = 16;
  localparam int NUM_ANALOG_MON = 4;
endpackage

// ===== testbench/amc_ctrl_chk.sv
`timescale 1ns/1ps
module amc_ctrl_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic digital_io_supply_ok,
  input wire logic digital_regulator_ok,
  input wire logic [amc_pkg::NUM_ANALOG_MON-1:0] analog_supply_ok,
  input wire logic start,
  input wire logic conversion_ready_n,
  input wire logic common_mode_output_enable,
  input wire logic high_speed_mode,
  input wire logic filter_active,
  input wire logic sampling_active
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable && pready && pwrite;
  wire logic dig_ok = digital_io_supply_ok && digital_regulator_ok;
  property p_cm; acc && paddr == amc_pkg::ADDR_FIRST_CFG |=> ##1
    common_mode_output_enable ==
    $past(pwdata[amc_pkg::FC_CM_EN_BIT], 2); endproperty
  a_cm: assert property (p_cm) else $error("cm enable wrong");
  property p_spd; acc && paddr == amc_pkg::ADDR_SECOND_CFG |=> ##1
    high_speed_mode == $past(pwdata[0], 2); endproperty
  a_spd: assert property (p_spd) else $error("speed wrong");
  property p_rdy; $fell(conversion_ready_n) && dig_ok
    |=> !conversion_ready_n [*2] ##1 conversion_ready_n; endproperty
  a_rdy: assert property (p_rdy) else $error("ready pulse");
  property p_sup; !dig_ok |-> ##[1:2] !filter_active; endproperty
  a_sup: assert property (p_sup) else $error("supply hold");
  property p_smp; filter_active |-> sampling_active; endproperty
  a_smp: assert property (p_smp) else $error("sampling off");
  property p_alv; !(&analog_supply_ok) ##1 (psel && !penable &&
    paddr == 8'h08) |=> prdata[1]; endproperty
  a_alv: assert property (p_alv) else $error("alv not set");
  property p_go; $rose(filter_active) |-> conversion_ready_n; endproperty
  a_go: assert property (p_go) else $error("ready at start");
  property p_apb; psel && !penable |=> pready ##1 !pready; endproperty
  a_apb: assert property (p_apb) else $error("pready timing");
endmodule
bind amc_ctrl amc_ctrl_chk u_chk (.*);

// ===== testbench/amc_host.sv
`timescale 1ns/1ps
module amc_host (
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel = 1'h0,
  output logic penable = 1'h0,
  output logic pwrite = 1'h0,
  output logic [7:0] paddr = 8'h00,
  output logic [31:0] pwdata = 32'h0
);
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // Released bus must not keep showing the old request
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// ===== testbench/amc_ctrl_tb_top.sv
`timescale 1ns/1ps
module amc_ctrl_tb_top;
  typedef struct {logic [31:0] cfg; int per;} amc_row_t;
  amc_row_t rows [5] = '{'{32'h01, 5}, '{32'h00, 5}, '{32'h09, 6},
    '{32'h05, 18}, '{32'h15, 30}};
  logic pclk = 1'h0, presetn = 1'h0, start = 1'h0;
  logic digital_io_supply_ok = 1'h1, digital_regulator_ok = 1'h1;
  logic [3:0] analog_supply_ok = 4'hF;
  logic psel, penable, pwrite, pready, pslverr, e;
  logic conversion_ready_n, common_mode_output_enable, high_speed_mode;
  logic filter_active, sampling_active;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int error_cnt = 0, total_checks = 0, cyc = 0, n, t0;
  amc_ctrl #(.RATIO_A(5), .RATIO_B(6), .MOD_DIV(1), .SPI_READY_CYC(2))
    DUT (.*);
  amc_host HOST (.*);
  // Counts are in master clocks, so one period serves either rate
  initial forever #2 pclk = ~pclk;
  always @(posedge pclk) if (++cyc == 6000) begin
    error_cnt++;
    end_of_test();
  end
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rd(logic [7:0] a);
    HOST.xfer(1'h0, a, 32'h0, q, e);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    HOST.xfer(1'h1, a, d, q, e);
  endtask
  // Counts at negedge so both edges of a period are seen alike
  task automatic fall();
    n = 0;
    do @(negedge pclk) n++; while (conversion_ready_n !== 1'h1 && n < 999);
    do @(negedge pclk) n++; while (conversion_ready_n !== 1'h0 && n < 999);
    // Hand back on a rising edge so callers drive inputs there
    @(posedge pclk);
  endtask
  task automatic go();
    @(posedge pclk);
    start <= 1'h1;
    fall();
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    repeat (8) @(posedge pclk);
    chk("ready_n", conversion_ready_n, 1);
    rd(8'h08);
    chk("status", q, 32'hB);
    wr(8'h08, 32'h3);
    rd(8'h08);
    chk("status_clr", q, 32'h8);
    rd(8'h04);
    chk("cfg2", q, 32'h1);
    chk("slverr_ok", e, 0);
    rd(8'h0C);
    chk("slverr", {e, q[0]}, 2'h2);
    for (int i = 0; i < 4; i++) begin
      analog_supply_ok <= ~(4'h1 << i);
      rd(8'h08);
      chk("alv", q[1], 1);
      analog_supply_ok <= 4'hF;
      wr(8'h08, 32'h0);
      rd(8'h08);
      chk("alv_keep", q[1], 1);
      wr(8'h08, 32'h2);
      rd(8'h08);
      chk("alv_clr", q[1], 0);
    end
    // Monitor low only at the clearing edge: the set must win
    fork
      wr(8'h08, 32'h2);
      begin
        repeat (2) @(posedge pclk);
        analog_supply_ok <= 4'hE;
        @(posedge pclk);
        analog_supply_ok <= 4'hF;
      end
    join
    rd(8'h08);
    chk("alv_win", q[1], 1);
    wr(8'h00, 32'h1);
    analog_supply_ok <= 4'h0;
    repeat (4) @(posedge pclk);
    analog_supply_ok <= 4'hF;
    rd(8'h00);
    chk("cm_keep", {q[0], common_mode_output_enable}, 2'h3);
    foreach (rows[i]) begin
      start <= 1'h0;
      repeat (40) @(posedge pclk);
      wr(8'h04, rows[i].cfg);
      repeat (2) @(posedge pclk);
      chk("speed", high_speed_mode, rows[i].cfg[0]);
      go();
      fall();
      chk("period", n, rows[i].per);
    end
    start <= 1'h0;
    wr(8'h04, 32'h3);
    repeat (40) @(posedge pclk);
    chk("standby", sampling_active, 0);
    go();
    t0 = n;
    start <= 1'h0;
    wr(8'h04, 32'h1);
    repeat (40) @(posedge pclk);
    chk("idle", {sampling_active, filter_active}, 2'h2);
    go();
    chk("wake", t0 - n, 24);
    // Flag must be clear so only the digital dip can set it
    wr(8'h08, 32'h2);
    rd(8'h08);
    chk("alv_pre", q[1], 0);
    digital_io_supply_ok <= 1'h0;
    repeat (3) @(posedge pclk);
    digital_io_supply_ok <= 1'h1;
    fall();
    rd(8'h08);
    chk("io_low", q[1], 1);
    presetn <= 1'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    fall();
    rd(8'h08);
    chk("por", {q[0], filter_active}, 2'h3);
    rd(8'h00);
    chk("cfg1_rst", q, 32'h0);
    end_of_test();
  end
endmodule
